// [rtl/srp_defs.svh]
/*
 Constants of the safety, reset and test-protection block: register map,
 field positions, reset values and sizes. Assumes inclusion by bare name.
*/
// Functional notes
// - Power Q-Channel has request check input plus active, accept, deny check outputs.
// - Clock-gate Q-Channel has the same check input and check outputs.
// - Fault manager has its own register port, apart from configuration port; here all registers share the one AXI4-Lite port.
// - Stream interfaces carry parity; both ends generate and check it.
// - ACE-Lite interfaces carry parity; both ends generate and check it.
// - Redundant logic on own reset tree; lockstep comparators catch tree faults.
// - Synchronised resets assert asynchronously, deassert synchronously to the clock.
// - Redundant main and fault-manager resets release two cycles after primaries.
// - Fault-manager resets touch only fault-manager registers.
// - Main resets clear everything except fault-manager registers; records survive.
// - Memory-test wrapper duplicated; copies compared at the RAM inputs.
// - Memory-test request seen in functional mode is reported as a fault.
// - Memory-test reset acts only when primary and redundant inputs both assert.
// - Scan reset-disable blocks that domain's internal reset assertion.
// - Scan clock-gate-force forces that domain's clock gate enables on.
// - Scan RAM-hold suppresses RAM accesses in that domain.
// - Fault manager collects all check errors, forwards them only when enabled; here errors of disabled checks are dropped, never recorded.
// - One error record per unit in registers, kept across functional reset.
// - Software enables each check individually and can inject errors.
`ifndef SRP_DEFS_SVH
`define SRP_DEFS_SVH

`define SRP_NUNIT        4
`define SRP_NCHK         8
`define SRP_RAM_AW       10
`define SRP_SYNC_W       ((`SRP_NUNIT - 1) * `SRP_NCHK + 5)
`define SRP_SYNC_RST     5'h05
`define SRP_RST_STAGES   2
`define SRP_RED_STAGES   4

`define SRP_REG_CTRL     12'h000
`define SRP_REG_SUMMARY  12'h004
`define SRP_PAGE_ENABLE  4'h1
`define SRP_PAGE_STATUS  4'h2
`define SRP_PAGE_INJECT  4'h3
`define SRP_ENABLE_RST   8'hff
`define SRP_FWD_RST      1'b0

`define SRP_CK_QCH       0
`define SRP_CK_STREAM    1
`define SRP_CK_ACE       2
`define SRP_CK_LOCKSTEP  3
`define SRP_CK_RAMCMP    4
`define SRP_CK_MTREQ     5

`define SRP_TD_UNIT_LSB  4
`define SRP_RESP_OKAY    2'h0
`define SRP_RESP_SLVERR  2'h2

`endif

// [rtl/srp_pkg.sv]
/*
 Types of the safety, reset and test-protection block.
 Assumes srp_defs.svh is on the include path.
*/
`include "srp_defs.svh"
package srp_pkg;
	typedef enum logic [2:0] {
		SRP_Q_RUN  = 3'h1,
		SRP_Q_STOP = 3'h2,
		SRP_Q_DENY = 3'h4
	} srp_qst_t;

	typedef struct packed {
		logic                   en;
		logic                   we;
		logic [`SRP_RAM_AW-1:0] addr;
		logic [31:0]            wdata;
	} srp_ram_t;

	typedef struct packed {
		srp_qst_t [1:0] q;
		srp_ram_t       ram;
		logic           have_aw;
		logic [11:0]    awaddr;
		logic           have_w;
		logic [31:0]    wdata;
		logic [3:0]     wstrb;
		logic           bvalid;
		logic [1:0]     bresp;
		logic           rvalid;
		logic [31:0]    rdata;
		logic [1:0]     rresp;
	} srp_main_t;

	typedef struct packed {
		srp_qst_t [1:0] q;
		srp_ram_t       ram;
	} srp_red_t;

	typedef struct packed {
		logic                                     fwd;
		logic [`SRP_NUNIT-1:0][`SRP_NCHK-1:0]     en;
		logic [`SRP_NUNIT-1:0][`SRP_NCHK-1:0]     st;
		logic                                     fault;
	} srp_fm_t;
endpackage

// [rtl/srp_top.sv]
/*
 Safety, reset and test protection with fault manager: Q-Channel check
 bits, stream and ACE-Lite parity, redundant lockstep copy, staged reset
 synchronisers, memory-test and scan guards, error records over AXI4-Lite.
 Assumes one clock; Q-Channel requests, the memory-test request and unit error
 lines arrive asynchronously; stream, ACE-Lite and memory-test RAM ports are on mclk.
*/
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "srp_defs.svh"
module srp_top (
	input  wire logic                                  mclk,
	input  wire logic                                  rstn,
	input  wire logic                                  rstn_red,
	input  wire logic                                  fm_rstn,
	input  wire logic                                  fm_rstn_red,
	input  wire logic                                  mtest_rstn,
	input  wire logic                                  mtest_rstn_red,
	input  wire logic                                  scan_rst_dis,
	input  wire logic                                  scan_rst_dis_red,
	input  wire logic                                  scan_cg_force,
	input  wire logic                                  scan_cg_force_red,
	input  wire logic                                  scan_ram_hold,
	input  wire logic                                  scan_ram_hold_red,
	input  wire logic                                  func_cg_en,
	output logic                                       cg_en,
	output logic                                       cg_en_red,
	output logic                                       mtest_rst_n,
	input  wire logic                                  power_request_n,
	input  wire logic                                  power_request_check_in,
	input  wire logic                                  power_busy,
	output logic                                       power_active,
	output logic                                       power_accept,
	output logic                                       power_deny,
	output logic                                       power_active_check_out,
	output logic                                       power_accept_check_out,
	output logic                                       power_deny_check_out,
	input  wire logic                                  clockgate_request_n,
	input  wire logic                                  clockgate_request_check_in,
	input  wire logic                                  clockgate_busy,
	output logic                                       clockgate_active,
	output logic                                       clockgate_accept,
	output logic                                       clockgate_deny,
	output logic                                       clockgate_active_check_out,
	output logic                                       clockgate_accept_check_out,
	output logic                                       clockgate_deny_check_out,
	input  wire logic                                  s_tvalid,
	input  wire logic                                  s_tvalid_chk,
	input  wire logic [7:0]                            s_tdata,
	input  wire logic                                  s_tdata_chk,
	output logic                                       s_tready,
	output logic                                       s_tready_chk,
	input  wire logic                                  ace_rvalid,
	input  wire logic                                  ace_rvalid_chk,
	input  wire logic [31:0]                           ace_rdata,
	input  wire logic [3:0]                            ace_rdata_chk,
	input  wire logic                                  ace_rready,
	output logic                                       ace_rready_chk,
	input  wire logic                                  mtest_req,
	input  wire srp_pkg::srp_ram_t                     mtest_ram,
	input  wire srp_pkg::srp_ram_t                     func_ram,
	output srp_pkg::srp_ram_t                          ram,
	input  wire logic [`SRP_NUNIT-1:1][`SRP_NCHK-1:0]  unit_err,
	output logic                                       fault_out,
	output logic                                       fault_out_chk,
	input  wire logic [11:0]                           awaddr,
	input  wire logic                                  awvalid,
	output logic                                       awready,
	input  wire logic [31:0]                           wdata,
	input  wire logic [3:0]                            wstrb,
	input  wire logic                                  wvalid,
	output logic                                       wready,
	output logic [1:0]                                 bresp,
	output logic                                       bvalid,
	input  wire logic                                  bready,
	input  wire logic [11:0]                           araddr,
	input  wire logic                                  arvalid,
	output logic                                       arready,
	output logic [31:0]                                rdata,
	output logic [1:0]                                 rresp,
	output logic                                       rvalid,
	input  wire logic                                  rready
);
	import srp_pkg::*;

	localparam int NU = `SRP_NUNIT;
	localparam int NC = `SRP_NCHK;
	localparam int SW = `SRP_SYNC_W;

	srp_main_t          m_q, m_d;
	srp_red_t           r_q, r_d;
	srp_fm_t            f_q, f_d;
	logic [3:0]         rst_in_n;
	logic [3:0]         rst_sync_n;
	logic [SW-1:0]      pin_raw, pin_meta, pin_s;
	logic [NU-1:1][NC-1:0] uerr_s;
	logic               pw_req_n_s, pw_chk_s, cg_req_n_s, cg_chk_s, mreq_s;
	logic [NC-1:0]      ev0;
	logic               wr_go, td_par_ok, ace_par_ok;
	logic [1:0]         req_n_s, busy;

	assign rst_in_n = {fm_rstn_red | scan_rst_dis_red, fm_rstn | scan_rst_dis,
	                   rstn_red | scan_rst_dis_red, rstn | scan_rst_dis};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_rsync
			localparam int STG = (gi % 2 == 1) ? `SRP_RED_STAGES : `SRP_RST_STAGES;
			logic [STG-1:0] sh_q;
			always_ff @(posedge mclk or negedge rst_in_n[gi]) begin
				if (!rst_in_n[gi]) begin
					sh_q <= '0;
				end else begin
					sh_q <= {sh_q[STG-2:0], 1'b1};
				end
			end
			assign rst_sync_n[gi] = sh_q[STG-1];
		end
	endgenerate

	// Asynchronous pins pass two flops before use
	assign pin_raw = {unit_err, mtest_req, clockgate_request_check_in, clockgate_request_n,
	                  power_request_check_in, power_request_n};
	always_ff @(posedge mclk or negedge rst_sync_n[0]) begin
		if (!rst_sync_n[0]) begin
			pin_meta <= SW'(`SRP_SYNC_RST);
			pin_s    <= SW'(`SRP_SYNC_RST);
		end else begin
			pin_meta <= pin_raw;
			pin_s    <= pin_meta;
		end
	end
	assign {uerr_s, mreq_s, cg_chk_s, cg_req_n_s, pw_chk_s, pw_req_n_s} = pin_s;
	assign req_n_s = {cg_req_n_s, pw_req_n_s};
	assign busy    = {clockgate_busy, power_busy};

	function automatic srp_qst_t qnext(input srp_qst_t q, input logic rq_n, input logic bz);
		case (q)
			SRP_Q_RUN:  qnext = rq_n ? SRP_Q_RUN : (bz ? SRP_Q_DENY : SRP_Q_STOP);
			SRP_Q_STOP: qnext = rq_n ? SRP_Q_RUN : SRP_Q_STOP;
			SRP_Q_DENY: qnext = rq_n ? SRP_Q_RUN : SRP_Q_DENY;
			default:    qnext = SRP_Q_RUN;
		endcase
	endfunction

	function automatic srp_ram_t ramsel(input logic mt, input logic hold);
		srp_ram_t v;
		v = mt ? mtest_ram : func_ram;
		if (hold) begin
			v.en = 1'b0;
			v.we = 1'b0;
		end
		ramsel = v;
	endfunction

	assign power_active           = power_busy;
	assign power_active_check_out = ~power_busy;
	assign power_accept           = m_q.q[0] == SRP_Q_STOP;
	assign power_deny             = m_q.q[0] == SRP_Q_DENY;
	assign power_accept_check_out = r_q.q[0] != SRP_Q_STOP;
	assign power_deny_check_out   = r_q.q[0] != SRP_Q_DENY;
	assign clockgate_active           = clockgate_busy;
	assign clockgate_active_check_out = ~clockgate_busy;
	assign clockgate_accept           = m_q.q[1] == SRP_Q_STOP;
	assign clockgate_deny             = m_q.q[1] == SRP_Q_DENY;
	assign clockgate_accept_check_out = r_q.q[1] != SRP_Q_STOP;
	assign clockgate_deny_check_out   = r_q.q[1] != SRP_Q_DENY;

	assign cg_en     = func_cg_en | scan_cg_force;
	assign cg_en_red = func_cg_en | scan_cg_force_red;
	assign mtest_rst_n = mtest_rstn | mtest_rstn_red;
	assign ram = m_q.ram;

	assign s_tready     = 1'b1;
	assign s_tready_chk = 1'b0;
	assign td_par_ok    = (s_tvalid != s_tvalid_chk) && (s_tdata_chk == ~^s_tdata);
	assign ace_rready_chk = ~ace_rready;
	always_comb begin
		ace_par_ok = ace_rvalid != ace_rvalid_chk;
		for (int b = 0; b < 4; b++) begin
			if (ace_rvalid && ace_rdata_chk[b] != ~^ace_rdata[8*b +: 8]) begin
				ace_par_ok = 1'b0;
			end
		end
	end

	// Unit-0 events from own checks
	always_comb begin
		ev0 = '0;
		ev0[`SRP_CK_QCH]      = (pw_req_n_s == pw_chk_s) || (cg_req_n_s == cg_chk_s);
		ev0[`SRP_CK_STREAM]   = !td_par_ok;
		ev0[`SRP_CK_ACE]      = !ace_par_ok;
		ev0[`SRP_CK_LOCKSTEP] = m_q.q != r_q.q;
		ev0[`SRP_CK_RAMCMP]   = m_q.ram != r_q.ram;
		ev0[`SRP_CK_MTREQ]    = mreq_s && mtest_rst_n;
	end

	assign awready = !m_q.have_aw;
	assign wready  = !m_q.have_w;
	assign arready = !m_q.rvalid;
	assign bvalid  = m_q.bvalid;
	assign bresp   = m_q.bresp;
	assign rvalid  = m_q.rvalid;
	assign rdata   = m_q.rdata;
	assign rresp   = m_q.rresp;
	assign wr_go   = m_q.have_aw && m_q.have_w && !m_q.bvalid;

	function automatic logic addr_hit(input logic [11:0] a);
		addr_hit = (a[11:2] == `SRP_REG_CTRL >> 2) || (a[11:2] == `SRP_REG_SUMMARY >> 2) ||
		           ((a[11:8] == `SRP_PAGE_ENABLE || a[11:8] == `SRP_PAGE_STATUS ||
		             a[11:8] == `SRP_PAGE_INJECT) && a[7:2] < NU);
	endfunction

	function automatic logic [31:0] rd(input logic [11:0] a);
		logic [31:0] v;
		logic [5:0]  ix;
		v  = '0;
		ix = a[7:2];
		if (a[11:2] == `SRP_REG_CTRL >> 2) begin
			v[0] = f_q.fwd;
		end else if (a[11:2] == `SRP_REG_SUMMARY >> 2) begin
			for (int u = 0; u < NU; u++) begin
				v[u] = |f_q.st[u];
			end
			v[NU] = f_q.fault;
		end else if (ix < NU) begin
			if (a[11:8] == `SRP_PAGE_ENABLE) begin
				v[NC-1:0] = f_q.en[ix[1:0]];
			end else if (a[11:8] == `SRP_PAGE_STATUS) begin
				v[NC-1:0] = f_q.st[ix[1:0]];
			end
		end
		rd = v;
	endfunction

	// Main domain: Q-Channel, RAM wrapper, register port
	always_comb begin
		m_d = m_q;
		for (int c = 0; c < 2; c++) begin
			m_d.q[c] = qnext(m_q.q[c], req_n_s[c], busy[c]);
		end
		m_d.ram = ramsel(mreq_s, scan_ram_hold);
		if (awvalid && !m_q.have_aw) begin
			m_d.have_aw = 1'b1;
			m_d.awaddr  = awaddr;
		end
		if (wvalid && !m_q.have_w) begin
			m_d.have_w = 1'b1;
			m_d.wdata  = wdata;
			m_d.wstrb  = wstrb;
		end
		if (m_q.bvalid && bready) begin
			m_d.bvalid = 1'b0;
		end
		if (wr_go) begin
			m_d.have_aw = 1'b0;
			m_d.have_w  = 1'b0;
			m_d.bvalid  = 1'b1;
			m_d.bresp   = addr_hit(m_q.awaddr) ? `SRP_RESP_OKAY : `SRP_RESP_SLVERR;
		end
		if (m_q.rvalid && rready) begin
			m_d.rvalid = 1'b0;
		end
		if (arvalid && !m_q.rvalid) begin
			m_d.rvalid = 1'b1;
			m_d.rdata  = rd(araddr);
			m_d.rresp  = addr_hit(araddr) ? `SRP_RESP_OKAY : `SRP_RESP_SLVERR;
		end
	end

	always_ff @(posedge mclk or negedge rst_sync_n[0]) begin
		if (!rst_sync_n[0]) begin
			m_q <= '{q: '{SRP_Q_RUN, SRP_Q_RUN}, default: '0};
		end else begin
			m_q <= m_d;
		end
	end

	always_comb begin
		r_d = r_q;
		for (int c = 0; c < 2; c++) begin
			r_d.q[c] = qnext(r_q.q[c], req_n_s[c], busy[c]);
		end
		r_d.ram = ramsel(mreq_s, scan_ram_hold_red);
	end

	always_ff @(posedge mclk or negedge rst_sync_n[1]) begin
		if (!rst_sync_n[1]) begin
			r_q <= '{q: '{SRP_Q_RUN, SRP_Q_RUN}, default: '0};
		end else begin
			r_q <= r_d;
		end
	end

	// Fault manager: records, enables, injection, forwarding
	always_comb begin
		logic [NU-1:0][NC-1:0] set, clr;
		logic [5:0]            ix;
		logic [3:0]            tu;
		f_d = f_q;
		set = '0;
		clr = '0;
		ix  = m_q.awaddr[7:2];
		tu  = s_tdata[7:`SRP_TD_UNIT_LSB];
		set[0] = ev0;
		for (int u = 1; u < NU; u++) begin
			set[u] = uerr_s[u];
		end
		if (s_tvalid && td_par_ok && tu < NU) begin
			set[tu[1:0]][s_tdata[2:0]] = 1'b1;
		end
		set = set & f_q.en;
		if (wr_go && m_q.wstrb[0]) begin
			if (m_q.awaddr[11:2] == `SRP_REG_CTRL >> 2) begin
				f_d.fwd = m_q.wdata[0];
			end else if (ix < NU) begin
				case (m_q.awaddr[11:8])
					`SRP_PAGE_ENABLE: f_d.en[ix[1:0]] = m_q.wdata[NC-1:0];
					`SRP_PAGE_STATUS: clr[ix[1:0]] = m_q.wdata[NC-1:0];
					`SRP_PAGE_INJECT: set[ix[1:0]] = set[ix[1:0]] | (m_q.wdata[NC-1:0] & f_q.en[ix[1:0]]);
					default:          f_d.fwd = f_q.fwd;
				endcase
			end
		end
		f_d.st    = (f_q.st & ~clr) | set;
		f_d.fault = f_q.fwd && |f_d.st;
	end

	always_ff @(posedge mclk or negedge rst_sync_n[2]) begin
		if (!rst_sync_n[2]) begin
			f_q <= '{fwd: `SRP_FWD_RST, en: {NU{`SRP_ENABLE_RST}}, default: '0};
		end else begin
			f_q <= f_d;
		end
	end

	logic fault_red_q;
	always_ff @(posedge mclk or negedge rst_sync_n[3]) begin
		if (!rst_sync_n[3]) begin
			fault_red_q <= 1'b0;
		end else begin
			fault_red_q <= f_d.fault;
		end
	end

	assign fault_out     = f_q.fault;
	assign fault_out_chk = ~fault_red_q;
endmodule

// [verification/srp_assertions.sv]
/*
 Checker for srp_top: check-bit copies, RAM hold, fault copy, reset idle
 state and register bus answers. Sees only srp_top ports; bound below.
*/
`timescale 1ns/10ps
module srp_assertions (
	input wire logic		mclk,
	input wire logic		rstn,
	input wire logic		fm_rstn,
	input wire logic		power_active,
	input wire logic		power_accept,
	input wire logic		power_deny,
	input wire logic		power_active_check_out,
	input wire logic		power_accept_check_out,
	input wire logic		power_deny_check_out,
	input wire logic		clockgate_active,
	input wire logic		clockgate_accept,
	input wire logic		clockgate_deny,
	input wire logic		clockgate_active_check_out,
	input wire logic		clockgate_accept_check_out,
	input wire logic		clockgate_deny_check_out,
	input wire logic		s_tready,
	input wire logic		s_tready_chk,
	input wire logic		ace_rready,
	input wire logic		ace_rready_chk,
	input wire logic		scan_ram_hold,
	input wire srp_pkg::srp_ram_t	ram,
	input wire logic		fault_out,
	input wire logic		fault_out_chk,
	input wire logic		arvalid,
	input wire logic		arready,
	input wire logic		rvalid,
	input wire logic		rready,
	input wire logic		bvalid,
	input wire logic		bready
);
	import srp_pkg::*;
	default clocking dc @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	pwr_check_a: assert property (
		{power_active_check_out, power_accept_check_out, power_deny_check_out} ==
		~{power_active, power_accept, power_deny}) else $error("power check outputs not inverted");
	cg_check_a: assert property (
		{clockgate_active_check_out, clockgate_accept_check_out, clockgate_deny_check_out} ==
		~{clockgate_active, clockgate_accept, clockgate_deny}) else $error("gate check outputs not inverted");
	stream_chk_a: assert property (s_tready_chk == !s_tready)
		else $error("stream ready check wrong");
	ace_chk_a: assert property (ace_rready_chk == !ace_rready)
		else $error("ace ready check wrong");
	ram_hold_a: assert property (scan_ram_hold |=> !ram.en && !ram.we)
		else $error("ram access during hold");
	fault_copy_a: assert property (@(posedge mclk) disable iff (!fm_rstn)
		fault_out_chk == !fault_out) else $error("fault check not inverse of fault");
	rst_idle_a: assert property (@(posedge mclk) disable iff (!fm_rstn)
		!rstn |-> !power_accept && !clockgate_accept && !bvalid && !rvalid && !ram.en)
		else $error("outputs active in reset");
	rd_answer_a: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	rd_done_a: assert property (rvalid && rready |=> !rvalid)
		else $error("read answer held after take");
	wr_done_a: assert property (bvalid && bready |=> !bvalid)
		else $error("write answer held after take");
endmodule
bind srp_top srp_assertions u_chk (.*);

// [verification/srp_qctl.sv]
/*
 Q-Channel controller model: lowers the request on go and raises it once
 the device accepts or denies. Assumes the device runs on the same clock.
*/
`timescale 1ns/10ps
module srp_qctl (
	input wire logic	mclk,
	input wire logic	rstn,
	input wire logic	go,
	input wire logic	bad,
	input wire logic	accept,
	input wire logic	deny,
	output logic		req_n,
	output logic		req_chk
);
	always @(posedge mclk or negedge rstn) begin
		if (!rstn)
			req_n <= 1'h1;
		else if (req_n && go && !accept && !deny)
			req_n <= 1'h0;
		else if (!req_n && (accept || deny))
			req_n <= 1'h1;
	end
	assign req_chk = bad ? req_n : !req_n;
endmodule

// [verification/srp_tb.sv]
/*
 Self-checking bench for srp_top: registers, Q-Channel, parity faults,
 memory-test, scan and reset retention. Needs srp_qctl and the checker.
*/
`timescale 1ns/10ps
`include "srp_defs.svh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin mismatches++; $display("mismatch %s exp %h got %h", n, e, s); end end
module testbench;
	import srp_pkg::*;
	logic mclk = '0, rstn = '0, rstn_red = '0, fm_rstn = '0, fm_rstn_red = '0, mtest_rstn = '1, mtest_rstn_red = '1;
	logic scan_rst_dis = '0, scan_rst_dis_red = '0, scan_cg_force = '0, scan_cg_force_red = '0, scan_ram_hold = '0;
	logic scan_ram_hold_red = '0, func_cg_en = '0, cg_en, cg_en_red, mtest_rst_n, mtest_req = '0, fault_out, fault_out_chk;
	logic power_request_n, power_request_check_in, power_busy = '0, power_active, power_accept, power_deny;
	logic power_active_check_out, power_accept_check_out, power_deny_check_out, clockgate_accept, clockgate_deny;
	logic clockgate_request_n, clockgate_request_check_in, clockgate_busy = '0, clockgate_active;
	logic clockgate_active_check_out, clockgate_accept_check_out, clockgate_deny_check_out;
	logic s_tvalid = '0, s_tvalid_chk = '1, s_tdata_chk = '1, s_tready, s_tready_chk;
	logic ace_rvalid = '0, ace_rvalid_chk = '1, ace_rready = '0, ace_rready_chk;
	logic awvalid = '0, awready, wvalid = '0, wready, bvalid, bready = '0, arvalid = '0, arready, rvalid, rready = '0;
	logic [7:0] s_tdata = '0;
	logic [31:0] ace_rdata = '0, wdata = '0, rdata;
	logic [3:0] ace_rdata_chk = 4'hf, wstrb = 4'hf;
	logic [11:0] awaddr = '0, araddr = '0;
	logic [1:0] bresp, rresp, go = '0, bad = '0;
	srp_ram_t mtest_ram = '0, func_ram = '0, ram;
	logic [`SRP_NUNIT-1:1][`SRP_NCHK-1:0] unit_err = '0;
	int mismatches = 0, checks = 0;
	srp_top uut (.*);
	srp_qctl u_pwr (.mclk(mclk), .rstn(rstn), .go(go[0]), .bad(bad[0]), .accept(power_accept),
		.deny(power_deny), .req_n(power_request_n), .req_chk(power_request_check_in));
	srp_qctl u_cg (.mclk(mclk), .rstn(rstn), .go(go[1]), .bad(bad[1]), .accept(clockgate_accept),
		.deny(clockgate_deny), .req_n(clockgate_request_n), .req_chk(clockgate_request_check_in));
	always #2.5 mclk = ~mclk;
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		@(negedge mclk);
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic [1:0] r);
		int n;
		logic ta, tw, tr, fin;
		n = 0;
		@(posedge mclk);
		if (w) begin
			awaddr <= a;
			wdata <= d;
			awvalid <= '1;
			wvalid <= '1;
			bready <= '1;
		end else begin
			araddr <= a;
			arvalid <= '1;
			rready <= '1;
		end
		do begin
			@(negedge mclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tr = arvalid && arready;
			fin = w ? bvalid && bready : rvalid && rready;
			q = rdata;
			r = w ? bresp : rresp;
			n++;
			@(posedge mclk);
			if (ta)
				awvalid <= '0;
			if (tw)
				wvalid <= '0;
			if (tr)
				arvalid <= '0;
		end while (!fin && n < 40);
		bready <= '0;
		rready <= '0;
		if (!fin) begin
			mismatches++;
			final_report;
		end
	endtask
	function automatic logic [11:0] ad(input logic [3:0] p, input int u);
		return {p, 8'(4 * u)};
	endfunction
	task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		logic [1:0] r;
		bus('0, a, '0, q, r);
		`CHK(n, e, q)
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic [1:0] r;
		bus('1, a, d, q, r);
	endtask
	task automatic clr;
		for (int u = 0; u < 4; u++)
			wr(ad(`SRP_PAGE_STATUS, u), 32'hff);
	endtask
	task automatic t_regs;
		logic [31:0] q;
		logic [1:0] r;
		rdc("ctrl", `SRP_REG_CTRL, 32'h0);
		for (int u = 0; u < 4; u++) begin
			rdc("enable", ad(`SRP_PAGE_ENABLE, u), 32'hff);
			rdc("status", ad(`SRP_PAGE_STATUS, u), 32'h0);
		end
		bus('0, 12'h400, 32'h0, q, r);
		`CHK("unmapped rd", {`SRP_RESP_SLVERR, 32'h0}, {r, q})
		bus('1, 12'h400, 32'h1, q, r);
		`CHK("unmapped wr", `SRP_RESP_SLVERR, r)
	endtask
	task automatic t_inject;
		wr(`SRP_REG_CTRL, 32'h1);
		wr(ad(`SRP_PAGE_INJECT, 2), 32'h5);
		rdc("inject", ad(`SRP_PAGE_STATUS, 2), 32'h5);
		rdc("summary", `SRP_REG_SUMMARY, 32'h14);
		`CHK("fault on", 1'h1, fault_out)
		wr(`SRP_REG_CTRL, 32'h0);
		cyc(2);
		`CHK("fault off", 1'h0, fault_out)
		wr(ad(`SRP_PAGE_ENABLE, 3), 32'hfe);
		wr(ad(`SRP_PAGE_INJECT, 3), 32'h3);
		rdc("masked", ad(`SRP_PAGE_STATUS, 3), 32'h2);
		wr(ad(`SRP_PAGE_ENABLE, 3), 32'hff);
		wr(ad(`SRP_PAGE_STATUS, 2), 32'h4);
		rdc("w1c", ad(`SRP_PAGE_STATUS, 2), 32'h1);
		clr;
	endtask
	task automatic t_qch;
		int n;
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk);
			power_busy <= i[1];
			clockgate_busy <= i[1];
			go[i[0]] <= '1;
			n = 0;
			do begin
				@(negedge mclk);
				n++;
			end while (!(i[0] ? clockgate_accept | clockgate_deny : power_accept | power_deny) && n < 20);
			if (n >= 20) begin
				mismatches++;
				final_report;
			end
			`CHK("qch", {~i[1], i[1], i[1], i[1], ~i[1], ~i[1]}, i[0] ? {clockgate_accept, clockgate_deny, clockgate_active, clockgate_accept_check_out, clockgate_deny_check_out, clockgate_active_check_out} : {power_accept, power_deny, power_active, power_accept_check_out, power_deny_check_out, power_active_check_out})
			@(posedge mclk);
			go <= '0;
			cyc(6);
			`CHK("qch release", 2'h0, {power_accept | clockgate_accept, power_deny | clockgate_deny})
		end
		rdc("qch clean", ad(`SRP_PAGE_STATUS, 0), 32'h0);
	endtask
	task automatic t_faults;
		@(posedge mclk);
		bad <= 2'h1;
		mtest_req <= '1;
		s_tvalid <= '1;
		s_tvalid_chk <= '0;
		s_tdata <= 8'h32;
		s_tdata_chk <= ^8'h32;
		ace_rvalid <= '1;
		ace_rvalid_chk <= '0;
		ace_rdata_chk <= 4'h0;
		ace_rready <= '1;
		@(posedge mclk);
		s_tvalid <= '0;
		s_tvalid_chk <= '1;
		s_tdata_chk <= ~^8'h32;
		ace_rvalid <= '0;
		ace_rvalid_chk <= '1;
		ace_rdata_chk <= 4'hf;
		cyc(4);
		@(posedge mclk);
		bad <= '0;
		mtest_req <= '0;
		cyc(4);
		rdc("unit0 faults", ad(`SRP_PAGE_STATUS, 0), 32'h27);
		clr;
		@(posedge mclk);
		s_tvalid <= '1;
		s_tvalid_chk <= '0;
		s_tdata_chk <= ~^8'h32;
		@(posedge mclk);
		s_tvalid <= '0;
		s_tvalid_chk <= '1;
		rdc("stream rec", ad(`SRP_PAGE_STATUS, 3), 32'h4);
		wr(ad(`SRP_PAGE_ENABLE, 0), 32'hdf);
		@(posedge mclk);
		mtest_req <= '1;
		cyc(4);
		@(posedge mclk);
		mtest_req <= '0;
		rdc("masked mtest", ad(`SRP_PAGE_STATUS, 0), 32'h0);
		wr(ad(`SRP_PAGE_ENABLE, 0), 32'hff);
		clr;
	endtask
	task automatic t_ram;
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk);
			mtest_rstn <= i[0];
			mtest_rstn_red <= i[1];
			func_cg_en <= i[0];
			scan_cg_force <= i[1];
			scan_cg_force_red <= i[1];
			cyc(0);
			`CHK("mtest rst", i[0] | i[1], mtest_rst_n)
			`CHK("cg force", {2{i[0] | i[1]}}, {cg_en, cg_en_red})
		end
		@(posedge mclk);
		func_ram <= '{'1, '1, 10'h2a5, 32'hc3a5_0f96};
		cyc(1);
		`CHK("ram pass", func_ram, ram)
		@(posedge mclk);
		scan_ram_hold <= '1;
		cyc(1);
		`CHK("ram hold", 2'h0, {ram.en, ram.we})
		@(posedge mclk);
		scan_ram_hold <= '0;
		func_ram <= '0;
		cyc(4);
		rdc("ram compare", ad(`SRP_PAGE_STATUS, 0), 32'h10);
		clr;
	endtask
	task automatic t_rst;
		@(posedge mclk);
		unit_err[1][3] <= '1;
		cyc(4);
		@(posedge mclk);
		unit_err[1][3] <= '0;
		wr(`SRP_REG_CTRL, 32'h1);
		wr(ad(`SRP_PAGE_ENABLE, 2), 32'h7f);
		@(posedge mclk);
		rstn <= '0;
		rstn_red <= '0;
		cyc(5);
		@(posedge mclk);
		rstn <= '1;
		rstn_red <= '1;
		cyc(6);
		`CHK("fault kept", 1'h1, fault_out)
		rdc("rec kept", ad(`SRP_PAGE_STATUS, 1), 32'h8);
		rdc("ctrl kept", `SRP_REG_CTRL, 32'h1);
		rdc("en kept", ad(`SRP_PAGE_ENABLE, 2), 32'h7f);
		@(posedge mclk);
		fm_rstn <= '0;
		fm_rstn_red <= '0;
		cyc(5);
		@(posedge mclk);
		fm_rstn <= '1;
		fm_rstn_red <= '1;
		cyc(6);
		rdc("rec cleared", ad(`SRP_PAGE_STATUS, 1), 32'h0);
		rdc("ctrl cleared", `SRP_REG_CTRL, 32'h0);
		rdc("en cleared", ad(`SRP_PAGE_ENABLE, 2), 32'hff);
	endtask
	initial begin
		cyc(5);
		@(posedge mclk);
		rstn <= '1;
		rstn_red <= '1;
		fm_rstn <= '1;
		fm_rstn_red <= '1;
		cyc(8);
		t_regs;
		t_inject;
		t_qch;
		t_faults;
		t_ram;
		t_rst;
		final_report;
	end
endmodule
